// >>> inc/ptmr_regs.vh
// Register offsets, field positions, reset values and timing counts of the periodic timer
`ifndef PTMR_REGS_VH
`define PTMR_REGS_VH
// ==========================================
// Register word indexes (byte address = index * 4)
`define PTMR_IDX_CMPA_LO     4'h0
`define PTMR_IDX_CMPA_HI     4'h1
`define PTMR_IDX_CMPP_LO     4'h2
`define PTMR_IDX_CMPP_HI     4'h3
`define PTMR_IDX_CTRL0       4'h4
`define PTMR_IDX_CTRL1       4'h5
`define PTMR_IDX_CNT_LO      4'h6
`define PTMR_IDX_CNT_HI      4'h7
`define PTMR_IDX_STATUS      4'h8
`define PTMR_IDX_LAST        4'h8
// ==========================================
// Control zero fields
`define PTMR_C0_HOLD         7
`define PTMR_C0_CKS_HI       6
`define PTMR_C0_CKS_LO       4
`define PTMR_C0_RUN          3
`define PTMR_C0_WMASK        8'hf8
// ==========================================
// Control one fields
`define PTMR_C1_MODE_HI      7
`define PTMR_C1_MODE_LO      6
`define PTMR_C1_PIN_HI       5
`define PTMR_C1_PIN_LO       4
`define PTMR_C1_LVL          3
`define PTMR_C1_INV          2
`define PTMR_C1_CAPS         1
`define PTMR_C1_CCLR         0
// ==========================================
// Reset values
`define PTMR_RST_BYTE        8'h00
`define PTMR_RST_WIDE        10'h000
// ==========================================
// Modes
`define PTMR_MODE_CMP        2'h0
`define PTMR_MODE_CAP        2'h1
`define PTMR_MODE_PWM        2'h2
`define PTMR_MODE_TMR        2'h3
// ==========================================
// Clock source selections
`define PTMR_CKS_SYS4        3'h0
`define PTMR_CKS_SYS         3'h1
`define PTMR_CKS_H16         3'h2
`define PTMR_CKS_H64         3'h3
`define PTMR_CKS_SUB0        3'h4
`define PTMR_CKS_SUB1        3'h5
`define PTMR_CKS_EXTR        3'h6
`define PTMR_CKS_EXTF        3'h7
// ==========================================
// Divider counts
`define PTMR_DIV_SYS         4
`define PTMR_DIV_H16         16
`define PTMR_DIV_H64         64
`endif

// >>> logic/ptmr_timer.v
// Periodic 10-bit timer with control registers on an Avalon-MM slave
`timescale 1ns/1ps
`include "ptmr_regs.vh"

module ptmr_timer #(
  parameter CW = 10                      // Counter width
) (
  input  wire        clock,              // System clock, 40 MHz
  input  wire        rst,                // Synchronous reset, active high
  input  wire [5:0]  avs_address,        // Byte address
  input  wire        avs_read,           // Read strobe
  input  wire        avs_write,          // Write strobe
  input  wire [31:0] avs_writedata,      // Write data
  input  wire [3:0]  avs_byteenable,     // Byte enables
  output reg  [31:0] avs_readdata,       // Read data
  output wire        avs_waitrequest,    // Stall
  output wire [1:0]  avs_response,       // Always OKAY
  input  wire        high_clk_en,        // High clock tick, system domain
  input  wire        sub_clk_en,         // Sub clock tick, system domain
  input  wire        external_clock_pin, // Asynchronous clock pin
  input  wire        capture_input_pin,  // Asynchronous capture pin
  output wire        timer_output_pin_o, // Output pin value
  output wire        timer_output_pin_oe_n, // Output enable, low drives
  output reg         match_a_pulse,      // Compare A event
  output reg         match_p_pulse,      // Compare P event
  output reg         capture_pulse       // Capture event
);

  // ==========================================
  // Registers
  // Compare high bytes keep only their two implemented bits
  reg [7:0]    cmpa_lo_reg;              // Compare A low byte
  reg [1:0]    cmpa_hi_reg;              // Compare A high bits
  reg [7:0]    cmpp_lo_reg;              // Compare P low byte
  reg [1:0]    cmpp_hi_reg;              // Compare P high bits
  reg [7:0]    ctrl0_reg;                // Control zero
  reg [7:0]    ctrl1_reg;                // Control one
  reg [CW-1:0] count_reg;                // Counter
  reg          out_reg;                  // Internal output level
  reg          run_d_reg;                // Run delayed, edge detect
  reg          pulse_done_reg;           // Single pulse finished
  reg          ack_reg;                  // Read answer phase
  reg [1:0]    ext_sync_reg;             // Clock pin synchroniser
  reg [1:0]    cap_sync_reg;             // Capture pin synchroniser
  reg          ext_d_reg;                // Clock pin previous
  reg          cap_d_reg;                // Trigger previous
  reg [1:0]    sys_div_reg;              // System divide by four
  reg [3:0]    h16_div_reg;              // High divide by 16
  reg [5:0]    h64_div_reg;              // High divide by 64
  reg          tick;                     // Counter enable, selected source

  // ==========================================
  // Field views
  // Named slices of the control bytes, then derived strobes
  wire          hold     = ctrl0_reg[`PTMR_C0_HOLD];
  wire [2:0]    cks      = ctrl0_reg[`PTMR_C0_CKS_HI:`PTMR_C0_CKS_LO];
  wire          run      = ctrl0_reg[`PTMR_C0_RUN];
  wire [1:0]    mode     = ctrl1_reg[`PTMR_C1_MODE_HI:`PTMR_C1_MODE_LO];
  wire [1:0]    pinf     = ctrl1_reg[`PTMR_C1_PIN_HI:`PTMR_C1_PIN_LO];
  wire          lvl      = ctrl1_reg[`PTMR_C1_LVL];
  wire          inv      = ctrl1_reg[`PTMR_C1_INV];
  wire          caps     = ctrl1_reg[`PTMR_C1_CAPS];
  wire          cclr     = ctrl1_reg[`PTMR_C1_CCLR];
  // Ten-bit compare values from their byte pairs
  wire [CW-1:0] cmpa     = {cmpa_hi_reg, cmpa_lo_reg};
  wire [CW-1:0] cmpp     = {cmpp_hi_reg, cmpp_lo_reg};
  // Run edge and waveform decodes
  wire          run_rise = run & ~run_d_reg;
  wire          single   = (mode == `PTMR_MODE_PWM) && (pinf == 2'h3);
  // Synchronised pins and capture trigger
  wire          ext_s    = ext_sync_reg[1];
  wire          cap_s    = cap_sync_reg[1];
  wire          trig     = caps ? ext_s : cap_s;
  // Count enable and compare events
  wire          counting = run & ~hold & tick;
  wire          hit_a    = counting && (count_reg == cmpa);
  wire          ovf      = counting && (&count_reg);
  // Period end on the P side: one count before compare P, so the
  // period equals compare P; a zero compare P wraps at full scale
  wire          p_end    = (cmpp == `PTMR_RST_WIDE) ? ovf :
                           (counting && (count_reg == cmpp - {{(CW-1){1'b0}}, 1'b1}));
  // Word index of the byte address
  wire [5:0]    idx      = {2'h0, avs_address[5:2]};

  // ==========================================
  // Bus answer: writes one cycle, reads two
  // Writes never stall; a read stalls one cycle while its data is
  // loaded into the read register, then is released with the data
  assign avs_waitrequest = avs_read & ~ack_reg;
  // No error responses
  assign avs_response    = 2'h0;

  // ==========================================
  // Pin synchronisers and edge history
  // Both pins are asynchronous: two flops each before any logic reads them,
  // and the history flops look at the second stage only
  always @(posedge clock) begin
    if (rst) begin
      // Synchronous reset to idle low
      ext_sync_reg <= 2'h0;
      cap_sync_reg <= 2'h0;
      ext_d_reg    <= 1'b0;
      cap_d_reg    <= 1'b0;
    end else begin
      // Shift in the raw pins
      ext_sync_reg <= {ext_sync_reg[0], external_clock_pin};
      cap_sync_reg <= {cap_sync_reg[0], capture_input_pin};
      // Last synchronised levels, for edge detection
      ext_d_reg    <= ext_s;
      cap_d_reg    <= trig;
    end
  end

  // ==========================================
  // Clock dividers
  // Free-running prescalers; each selected rate leaves here as a
  // one-cycle tick, so the counter never sees a second clock
  always @(posedge clock) begin
    if (rst) begin
      // Synchronous reset to zero
      sys_div_reg <= 2'h0;
      h16_div_reg <= 4'h0;
      h64_div_reg <= 6'h0;
    end else begin
      // System divide by four runs every cycle
      sys_div_reg <= sys_div_reg + 2'h1;
      // High clock dividers step on high clock ticks only
      if (high_clk_en) begin
        h16_div_reg <= h16_div_reg + 4'h1;
        h64_div_reg <= h64_div_reg + 6'h1;
      end
    end
  end

  // ==========================================
  // Clock source select
  // One tick per period of the chosen source; the pin edges are taken
  // from the synchronised copy. Both sub clock codes give the same tick.
  always @* begin
    case (cks)
      `PTMR_CKS_SYS4: tick = (sys_div_reg == 2'h3);
      `PTMR_CKS_SYS:  tick = 1'b1;
      `PTMR_CKS_H16:  tick = high_clk_en && (h16_div_reg == 4'hf);
      `PTMR_CKS_H64:  tick = high_clk_en && (h64_div_reg == 6'h3f);
      `PTMR_CKS_SUB0: tick = sub_clk_en;
      `PTMR_CKS_SUB1: tick = sub_clk_en;
      `PTMR_CKS_EXTR: tick = ext_s & ~ext_d_reg;
      default:        tick = ~ext_s & ext_d_reg;
    endcase
  end

  // ==========================================
  // Counter, capture and output logic
  // A run rising edge restarts the count; otherwise the count advances
  // only on a tick while running and not held. Run low or hold high
  // freezes it with its value kept. Events are one-cycle pulses.
  always @(posedge clock) begin
    if (rst) begin
      // Synchronous reset: count zero, pin level low, no events
      count_reg      <= `PTMR_RST_WIDE;
      out_reg        <= 1'b0;
      run_d_reg      <= 1'b0;
      pulse_done_reg <= 1'b0;
      match_a_pulse  <= 1'b0;
      match_p_pulse  <= 1'b0;
      capture_pulse  <= 1'b0;
    end else begin
      // Defaults: remember run, no event this cycle
      run_d_reg     <= run;
      match_a_pulse <= 1'b0;
      match_p_pulse <= 1'b0;
      capture_pulse <= 1'b0;
      if (run_rise) begin
        // Restart: clear the count and rearm the single pulse
        count_reg      <= `PTMR_RST_WIDE;
        pulse_done_reg <= 1'b0;
        if (mode == `PTMR_MODE_CMP)
          out_reg <= lvl;
      end else if (counting) begin
        // Plain increment; a clear below overrides it
        count_reg <= count_reg + {{(CW-1){1'b0}}, 1'b1};
        match_a_pulse <= hit_a;
        // P event marks the end of each period
        match_p_pulse <= p_end;
        case (mode)
          // Compare output and plain timer share the clear rules
          `PTMR_MODE_CMP, `PTMR_MODE_TMR: begin
            if (cclr ? hit_a : p_end)
              count_reg <= `PTMR_RST_WIDE;
            // Pin action on compare A only; P never touches the pin
            if (hit_a) begin
              case (pinf)
                2'h1:    out_reg <= 1'b0;
                2'h2:    out_reg <= 1'b1;
                2'h3:    out_reg <= ~out_reg;
                default: out_reg <= out_reg;
              endcase
            end
          end
          // Waveform modes: P sets the period, A the duty or pulse width
          `PTMR_MODE_PWM: begin
            if (single) begin
              // Single pulse never clears the count; A ends the pulse
              if (hit_a)
                pulse_done_reg <= 1'b1;
            end else if (p_end) begin
              count_reg <= `PTMR_RST_WIDE;
            end
          end
          // Capture: free run up to the P limit
          default: begin
            if (p_end)
              count_reg <= `PTMR_RST_WIDE;
          end
        endcase
      end
      // Capture runs on system clock while enabled
      // Edge chosen by the pin field; code 3 disables capture
      if (run && mode == `PTMR_MODE_CAP) begin
        case (pinf)
          2'h0:    capture_pulse <= trig & ~cap_d_reg;
          2'h1:    capture_pulse <= ~trig & cap_d_reg;
          2'h2:    capture_pulse <= trig ^ cap_d_reg;
          default: capture_pulse <= 1'b0;
        endcase
      end
    end
  end

  // ==========================================
  // Output pin shaping
  // Compare mode shows the held level; waveform modes derive the level from the pin
  // field, the count or the single pulse state and apply the active level choice.
  // Inversion comes last, in every mode that drives the pin.
  reg pwm_act;                                // Waveform active
  reg pin_lvl;                                // Level before inversion
  always @* begin
    // Defaults: idle waveform, held level
    pwm_act = 1'b0;
    pin_lvl = out_reg;
    if (mode == `PTMR_MODE_PWM) begin
      case (pinf)
        2'h0:    pwm_act = 1'b0;
        2'h1:    pwm_act = 1'b1;
        2'h2:    pwm_act = run && (count_reg < cmpa);
        default: pwm_act = run && ~pulse_done_reg;
      endcase
      // Active level choice
      pin_lvl = lvl ? pwm_act : ~pwm_act;
    end
  end
  assign timer_output_pin_o    = pin_lvl ^ inv;
  // Pin released in timer and capture modes
  assign timer_output_pin_oe_n = (mode == `PTMR_MODE_TMR) ||
                                 (mode == `PTMR_MODE_CAP);

  // ==========================================
  // Register writes
  // Only byte lane 0 carries data. Hardware updates (pulse end,
  // capture) are written after the bus decode, so they win a tie.
  always @(posedge clock) begin
    if (rst) begin
      // Synchronous reset of every software register
      cmpa_lo_reg <= `PTMR_RST_BYTE;
      cmpa_hi_reg <= 2'h0;
      cmpp_lo_reg <= `PTMR_RST_BYTE;
      cmpp_hi_reg <= 2'h0;
      ctrl0_reg   <= `PTMR_RST_BYTE;
      ctrl1_reg   <= `PTMR_RST_BYTE;
    end else begin
      if (avs_write && avs_byteenable[0]) begin
        // Decode the word index; unmapped words are ignored
        case (idx[3:0])
          `PTMR_IDX_CMPA_LO: cmpa_lo_reg <= avs_writedata[7:0];
          `PTMR_IDX_CMPA_HI: cmpa_hi_reg <= avs_writedata[1:0];
          `PTMR_IDX_CMPP_LO: cmpp_lo_reg <= avs_writedata[7:0];
          `PTMR_IDX_CMPP_HI: cmpp_hi_reg <= avs_writedata[1:0];
          `PTMR_IDX_CTRL0:   ctrl0_reg   <= avs_writedata[7:0] & `PTMR_C0_WMASK;
          `PTMR_IDX_CTRL1:   ctrl1_reg   <= avs_writedata[7:0];
          default:           ;
        endcase
      end
      // Single pulse ends by clearing run on compare A
      if (counting && single && hit_a)
        ctrl0_reg[`PTMR_C0_RUN] <= 1'b0;
      // Capture stores counter into compare A
      if (capture_pulse) begin
        cmpa_lo_reg <= count_reg[7:0];
        cmpa_hi_reg <= count_reg[9:8];
      end
    end
  end

  // ==========================================
  // Register reads, answered one cycle late
  // Data is loaded on the first read cycle and held until the next
  // read; unmapped words and unused bits read as zero
  always @(posedge clock) begin
    if (rst) begin
      // Synchronous reset: no answer pending, data zero
      ack_reg      <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      // Answer flag alternates, so each read stalls exactly one cycle
      ack_reg <= avs_read & ~ack_reg;
      // Load read data once per read
      if (avs_read && !ack_reg) begin
        case (idx[3:0])
          `PTMR_IDX_CMPA_LO: avs_readdata <= {24'h0, cmpa_lo_reg};
          `PTMR_IDX_CMPA_HI: avs_readdata <= {30'h0, cmpa_hi_reg};
          `PTMR_IDX_CMPP_LO: avs_readdata <= {24'h0, cmpp_lo_reg};
          `PTMR_IDX_CMPP_HI: avs_readdata <= {30'h0, cmpp_hi_reg};
          `PTMR_IDX_CTRL0:   avs_readdata <= {24'h0, ctrl0_reg};
          `PTMR_IDX_CTRL1:   avs_readdata <= {24'h0, ctrl1_reg};
          `PTMR_IDX_CNT_LO:  avs_readdata <= {24'h0, count_reg[7:0]};
          `PTMR_IDX_CNT_HI:  avs_readdata <= {30'h0, count_reg[9:8]};
          `PTMR_IDX_STATUS:  avs_readdata <= {29'h0, pulse_done_reg, out_reg, run};
          default:           avs_readdata <= 32'h0;
        endcase
      end
    end
  end

endmodule

// >>> dv/ptmr_timer_assertions.sv
// Port-level assertions of the periodic timer
`timescale 1ns/1ps
module ptmr_checker #(
  parameter CW = 10                       // Counter width
) (
  input wire        clock,
  input wire        rst,
  input wire [5:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0]  avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire [1:0]  avs_response,
  input wire        high_clk_en,
  input wire        sub_clk_en,
  input wire        external_clock_pin,
  input wire        capture_input_pin,
  input wire        timer_output_pin_o,
  input wire        timer_output_pin_oe_n,
  input wire        match_a_pulse,
  input wire        match_p_pulse,
  input wire        capture_pulse
);
  // ==========
  // Shadow copies of the control bytes
  reg  [7:0] c0_reg;                      // Control zero as written
  reg  [7:0] c1_reg;                      // Control one as written
  wire       wr_ok  = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire       rd_ok  = avs_read && !avs_waitrequest;
  wire [1:0] mode   = c1_reg[7:6];        // Operating mode field
  wire       run_up = wr_ok && avs_address[5:2] == 4'h4 && avs_writedata[3] && !c0_reg[3];
  // Track writes to both control bytes
  always @(posedge clock) begin
    if (rst) begin
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
    end else if (wr_ok && avs_address[5:2] == 4'h4) begin
      c0_reg <= avs_writedata[7:0];
    end else if (wr_ok && avs_address[5:2] == 4'h5) begin
      c1_reg <= avs_writedata[7:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // Bus and output checks
  a_read_wait_one: assert property (
    avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read not answered in one cycle");
  a_write_no_wait: assert property (
    avs_write |-> !avs_waitrequest) else $error("write stalled");
  a_read_upper_zero: assert property (
    rd_ok |-> avs_readdata[31:8] == 24'h0) else $error("read data above bit 7 not zero");
  a_cmpa_hi_zero: assert property (
    rd_ok && avs_address[5:2] == 4'h1 |-> avs_readdata[7:2] == 6'h00) else $error("compare A high bits set");
  a_cmpp_hi_zero: assert property (
    rd_ok && avs_address[5:2] == 4'h3 |-> avs_readdata[7:2] == 6'h00) else $error("compare P high bits set");
  a_timer_mode_float: assert property (
    mode == 2'h3 |-> timer_output_pin_oe_n) else $error("pin driven in timer mode");
  a_compare_mode_drive: assert property (
    mode == 2'h0 |-> !timer_output_pin_oe_n) else $error("pin not driven in compare mode");
  a_run_initial_level: assert property (
    run_up && mode == 2'h0 |-> ##2 timer_output_pin_o == (c1_reg[3] ^ c1_reg[2]))
    else $error("initial level not restored");
  a_pwm_forced_level: assert property (
    mode == 2'h2 && !c1_reg[5] && c0_reg[3]
    |-> timer_output_pin_o == ((c1_reg[4] ? c1_reg[3] : !c1_reg[3]) ^ c1_reg[2]))
    else $error("forced pwm level wrong");
  a_no_action_hold: assert property (
    mode == 2'h0 && c1_reg[5:4] == 2'h0 && !avs_write && !$past(avs_write)
    |=> $stable(timer_output_pin_o)) else $error("output moved with no action");
endmodule
bind ptmr_timer ptmr_checker #(.CW(CW)) u_ptmr_checker (
  .clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .high_clk_en(high_clk_en), .sub_clk_en(sub_clk_en), .external_clock_pin(external_clock_pin),
  .capture_input_pin(capture_input_pin), .timer_output_pin_o(timer_output_pin_o),
  .timer_output_pin_oe_n(timer_output_pin_oe_n), .match_a_pulse(match_a_pulse),
  .match_p_pulse(match_p_pulse), .capture_pulse(capture_pulse));

// >>> dv/testbench.sv
// Self-checking bench of the periodic timer
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [5:0] a; logic [3:0] b; logic [7:0] d; logic [7:0] e;} ptmr_row_t;
  // ==========
  // Design ports and scratch
  reg         clock    = 1'h0;
  reg         rst      = 1'h1;
  reg  [5:0]  address  = 6'h00;
  reg         rd_s     = 1'h0;            // Read strobe
  reg         wr_s     = 1'h0;            // Write strobe
  reg  [31:0] wdata    = 32'h0;
  reg  [3:0]  be       = 4'h1;
  reg         hi_en    = 1'h0;            // High clock tick
  reg         sub_en   = 1'h0;            // Sub clock tick
  reg         ext_pin  = 1'h0;            // External clock pin
  reg         cap_pin  = 1'h0;            // Capture pin
  reg  [7:0]  tick     = 8'h00;           // Stimulus phase
  wire [31:0] rdata;
  wire        waitreq;
  wire        pin_o;
  wire        pin_oe_n;
  wire        mat_a;
  int         miscompares = 0;
  int         compares    = 0;
  int         i;
  int         n;
  int         ex [8] = '{64, 256, 8, 2, 32, 32, 16, 16};
  reg  [31:0] q;
  reg  [9:0]  v1;
  reg  [9:0]  v2;
  reg         lvl;
  reg         inv;
  reg         e;
  reg  [1:0]  pn;
  ptmr_row_t  rows [8] = '{'{6'h00, 4'h1, 8'ha5, 8'ha5}, '{6'h00, 4'he, 8'h11, 8'ha5},
    '{6'h04, 4'h1, 8'hff, 8'h03}, '{6'h08, 4'h1, 8'h5a, 8'h5a}, '{6'h0c, 4'h1, 8'hfe, 8'h02},
    '{6'h10, 4'h1, 8'hf7, 8'hf0}, '{6'h18, 4'h1, 8'hff, 8'h00}, '{6'h24, 4'h1, 8'hff, 8'h00}};
  ptmr_timer #(.CW(10)) dut (
    .clock(clock), .rst(rst), .avs_address(address), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .avs_response(), .high_clk_en(hi_en), .sub_clk_en(sub_en), .external_clock_pin(ext_pin),
    .capture_input_pin(cap_pin), .timer_output_pin_o(pin_o), .timer_output_pin_oe_n(pin_oe_n),
    .match_a_pulse(mat_a), .match_p_pulse(), .capture_pulse());
  always #12.5 clock = ~clock;
  // Tick sources: high every 2, sub every 8, pin period 16
  always @(posedge clock) begin
    tick <= tick + 8'h01;
    hi_en <= tick[0];
    sub_en <= (tick[2:0] == 3'h7);
    ext_pin <= tick[3];
  end
  // ==========
  // Tasks
  task complete_run();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task check(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low
  task bus(input rw, input [5:0] a, input [3:0] b, input [7:0] d, output [31:0] r);
    int w;
    @(posedge clock);
    address <= a;
    be <= b;
    wdata <= {24'h0, d};
    rd_s <= rw;
    wr_s <= !rw;
    w = 0;
    do begin
      @(posedge clock);
      w++;
    end while (waitreq !== 1'h0 && w < 20);
    r = rdata;
    rd_s <= 1'h0;
    wr_s <= 1'h0;
    if (waitreq !== 1'h0) begin
      miscompares++;
      complete_run();
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    reg [31:0] r;
    bus(1'h0, a, 4'h1, d, r);
  endtask
  task rd(input [5:0] a, output [31:0] r);
    bus(1'h1, a, 4'h1, 8'h00, r);
  endtask
  task cnt(output [9:0] v);
    reg [31:0] lo;
    reg [31:0] hi;
    rd(6'h18, lo);
    rd(6'h1c, hi);
    v = {hi[1:0], lo[7:0]};
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    for (i = 0; i < 8; i++) begin
      bus(1'h0, rows[i].a, rows[i].b, rows[i].d, q);
      rd(rows[i].a, q);
      check(q, {24'h0, rows[i].e});
    end
    // Second reset clears every software register
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    for (i = 0; i < 6; i++) begin
      rd({i[3:0], 2'h0}, q);
      check(q, 32'h0);
    end
    // Hold, stop and restart in timer mode
    wr(6'h14, 8'hc0);
    wr(6'h10, 8'h18);
    repeat (20) @(posedge clock);
    check(pin_oe_n, 1'h1);
    wr(6'h10, 8'h98);
    cnt(v1);
    repeat (10) @(posedge clock);
    cnt(v2);
    check(v2, v1);
    wr(6'h10, 8'h18);
    repeat (5) @(posedge clock);
    cnt(v2);
    check(v2 > v1, 1);
    wr(6'h10, 8'h10);
    cnt(v1);
    repeat (10) @(posedge clock);
    cnt(v2);
    check(v2, v1);
    wr(6'h10, 8'h18);
    cnt(v2);
    check(v2 < 10'h008, 1);
    // Every clock source over a fixed window
    for (i = 0; i < 8; i++) begin
      wr(6'h10, 8'h00);
      wr(6'h10, {1'h0, i[2:0], 4'h8});
      repeat (256) @(posedge clock);
      wr(6'h10, {1'h1, i[2:0], 4'h8});
      cnt(v1);
      n = ex[i] / 32 + 1;
      check(v1 >= ex[i] - n && v1 <= ex[i] + n, 1);
    end
    // Compare mode: every action, level and inversion
    wr(6'h10, 8'h10);
    wr(6'h00, 8'h05);
    for (i = 0; i < 16; i++) begin
      pn = i[3:2];
      lvl = i[1];
      inv = i[0];
      e = (pn == 2'h0) ? lvl : ((pn == 2'h3) ? !lvl : pn[1]);
      wr(6'h10, 8'h10);
      wr(6'h14, {2'h0, pn, lvl, inv, 2'h0});
      wr(6'h10, 8'h18);
      repeat (2) @(posedge clock);
      check(pin_o, lvl ^ inv);
      n = 0;
      while (mat_a !== 1'h1 && n < 2000) begin
        @(posedge clock);
        n++;
      end
      if (n >= 2000) begin
        miscompares++;
        complete_run();
      end
      repeat (3) @(posedge clock);
      check(pin_o, e ^ inv);
      wr(6'h10, 8'h10);
      wr(6'h10, 8'h18);
      repeat (2) @(posedge clock);
      check(pin_o, lvl ^ inv);
    end
    // Pwm mode: forced levels and a 2 of 8 duty
    wr(6'h10, 8'h10);
    wr(6'h00, 8'h02);
    wr(6'h08, 8'h08);
    for (i = 0; i < 3; i++) begin
      wr(6'h14, {2'h2, i[1:0], 4'h8});
      wr(6'h10, 8'h18);
      repeat (4) @(posedge clock);
      n = 0;
      repeat (16) begin
        @(posedge clock);
        n += (pin_o === 1'h1);
      end
      check(n, (i == 0) ? 0 : ((i == 1) ? 16 : 4));
      wr(6'h10, 8'h10);
    end
    // Single pulse: active from run until compare A, then run drops
    wr(6'h14, 8'hb8);
    wr(6'h10, 8'h18);
    n = 0;
    repeat (16) begin
      @(posedge clock);
      n += (pin_o === 1'h1);
    end
    check(n, 4);
    rd(6'h10, q);
    check(q, 32'h10);
    // Compare mode with clear on A: the count never passes A
    wr(6'h14, 8'h01);
    wr(6'h10, 8'h18);
    repeat (40) @(posedge clock);
    cnt(v1);
    check(v1 <= 10'h002, 1);
    wr(6'h10, 8'h10);
    // Capture mode: each trigger edge selection
    wr(6'h08, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr(6'h14, {2'h1, i[1:0], 4'h0});
      wr(6'h00, 8'h00);
      wr(6'h10, 8'h18);
      repeat (20) @(posedge clock);
      cap_pin <= 1'h1;
      repeat (6) @(posedge clock);
      rd(6'h00, q);
      check(q != 32'h0, i == 0 || i == 2);
      cap_pin <= 1'h0;
      repeat (6) @(posedge clock);
      rd(6'h00, q);
      check(q != 32'h0, i != 3);
      wr(6'h10, 8'h10);
    end
    complete_run();
  end
endmodule
